// [hdl/pwmtc_pkg.sv]
// package: register map, field positions and encodings of the pwm timer
package pwmtc_pkg;
    // ========================================================
    // register addresses (plain port, 16-bit data)
    localparam logic [15:0] ADDR_CTL   = 16'h5400;
    localparam logic [15:0] ADDR_CNT   = 16'h5402;
    localparam logic [15:0] ADDR_CCCTL = 16'h5404;
    localparam logic [15:0] ADDR_CCA   = 16'h5406;
    localparam logic [15:0] ADDR_CCB   = 16'h5408;
    localparam logic [15:0] ADDR_CLK   = 16'h5068;
    // ========================================================
    // counter control fields
    localparam int CTL_RUN    = 0;
    localparam int CTL_CLR    = 1;
    localparam int CTL_ONESH  = 2;
    localparam int CTL_BUF    = 3;
    localparam int CTL_SEL_LO = 4;
    localparam int CTL_HALF   = 6;
    localparam logic [15:0] CTL_RW_MASK = 16'h007D;
    // count clock control fields
    localparam int CLK_EN     = 0;
    localparam int CLK_MULTI  = 1;
    localparam int CLK_SRC_LO = 2;
    localparam int CLK_DIV_LO = 4;
    // compare capture control fields
    localparam int CC_AFUNC   = 0;
    localparam int CC_AINV    = 1;
    localparam int CC_AMD_LO  = 4;
    localparam int CC_ATRG_LO = 6;
    localparam int CC_BFUNC   = 8;
    localparam int CC_BINV    = 9;
    localparam int CC_BMD_LO  = 12;
    localparam int CC_BTRG_LO = 14;
    localparam logic [15:0] CC_RW_MASK = 16'hF3F3;
    // ========================================================
    // reset values
    localparam logic [15:0] RST_REG16 = 16'h0000;
    localparam logic [7:0]  RST_REG8  = 8'h00;
    // clock sources
    typedef enum logic [1:0]
    {
        SRC_OSC_A = 2'b00,
        SRC_OSC_B = 2'b01,
        SRC_OSC_C = 2'b10,
        SRC_EXT   = 2'b11
    } pwmtc_src_t;
    // capture trigger edges
    typedef enum logic [1:0]
    {
        TRG_NONE = 2'b00,
        TRG_RISE = 2'b01,
        TRG_FALL = 2'b10,
        TRG_BOTH = 2'b11
    } pwmtc_trg_t;
endpackage

// [hdl/pwmtc_unit_if.sv]
// interface: one compare/capture unit to the channel core
`timescale 1ns/1ps
interface pwmtc_unit_if;
    logic        funcCapture; // 1 = capture register
    logic [1:0]  trigSel;     // capture trigger edge
    logic        capIn;       // synchronised capture pin
    logic        wrStb;       // software write of value
    logic [15:0] wrData;      // software data
    logic        bufOn;       // compare buffer enable
    logic        reload;      // period end, load buffer
    logic [15:0] count;       // counter value
    logic [15:0] value;       // visible compare/capture value
    logic        match;       // comparator hit, registered, high the cycle after count equals active value
    modport core (output funcCapture, trigSel, capIn, wrStb, wrData,
                  bufOn, reload, count, input value, match);
    modport unit (input funcCapture, trigSel, capIn, wrStb, wrData,
                  bufOn, reload, count, output value, match);
endinterface

// [hdl/pwmtc_unit.sv]
// compare/capture unit: value register, buffer, edge capture, match
`timescale 1ns/1ps
module pwmtc_unit
(
    input  wire logic   clk,   // core clock
    input  wire logic   rst_n, // async reset, active low
    pwmtc_unit_if.unit  u      // link to channel core
);
    logic [15:0] value_r, value_nxt;
    logic [15:0] active_r, active_nxt;
    logic        capPrev_r, capPrev_nxt;
    logic        match_r, match_nxt;
    logic        edgeHit;

    // ========================================================
    // edge select, local to each unit
    always_comb
    begin
        unique case (pwmtc_pkg::pwmtc_trg_t'(u.trigSel))
            pwmtc_pkg::TRG_NONE: edgeHit = 1'b0;
            pwmtc_pkg::TRG_RISE: edgeHit = u.capIn & ~capPrev_r;
            pwmtc_pkg::TRG_FALL: edgeHit = ~u.capIn & capPrev_r;
            pwmtc_pkg::TRG_BOTH: edgeHit = u.capIn ^ capPrev_r;
        endcase
    end

    // capture wins over software write in the same cycle
    always_comb
    begin
        value_nxt   = value_r;
        active_nxt  = active_r;
        capPrev_nxt = u.capIn;
        if (u.funcCapture && edgeHit)
            value_nxt = u.count;
        else if (u.wrStb)
            value_nxt = u.wrData;
        // buffered values only reach the comparator at period end
        if (!u.bufOn || u.reload)
            active_nxt = value_nxt;
        match_nxt = !u.funcCapture && (u.count == active_r);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            value_r   <= pwmtc_pkg::RST_REG16;
            active_r  <= pwmtc_pkg::RST_REG16;
            capPrev_r <= 1'b0;
            match_r   <= 1'b0;
        end
        else
        begin
            value_r   <= value_nxt;
            active_r  <= active_nxt;
            capPrev_r <= capPrev_nxt;
            match_r   <= match_nxt;
        end
    end

    assign u.value = value_r;
    assign u.match = match_r;
endmodule

// [hdl/pwmtc_clkdiv.sv]
// count clock prescaler: source select, enable, power-of-two divider
`timescale 1ns/1ps
module pwmtc_clkdiv
#(
    parameter int DIV_W = 15  // prescaler width
)
(
    input  wire logic       clk,     // core clock
    input  wire logic       rst_n,   // async reset, active low
    input  wire logic       enable,  // count clock enable
    input  wire logic [3:0] divSel,  // ratio is 1/2^divSel
    input  wire logic [3:0] srcTick, // synchronised source ticks
    input  wire logic [1:0] srcSel,  // source select
    output logic            tick     // one count clock pulse
);
    logic [DIV_W-1:0] pre_r, pre_nxt;
    logic             tick_r, tick_nxt;
    logic             srcPulse;
    logic [DIV_W-1:0] lowMask;

    // ========================================================
    // pick the selected source tick
    assign srcPulse = enable & srcTick[srcSel];

    // a tick fires when all low divSel prescaler bits wrap together;
    // one bit alone would tick on half of the pulses, not one in 2^n
    always_comb
    begin
        pre_nxt  = pre_r;
        tick_nxt = 1'b0;
        for (int i = 0; i < DIV_W; i++)
            lowMask[i] = (i < int'(divSel));
        if (!enable)
            pre_nxt = '0;
        else if (srcPulse)
        begin
            pre_nxt  = pre_r + 1'b1;
            tick_nxt = &(pre_r | ~lowMask);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_r  <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            pre_r  <= pre_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule

// [hdl/pwmtc_timer.sv]
// top: one channel of the 16-bit pwm timer with two compare/capture units
`timescale 1ns/1ps
module pwmtc_timer
#(
    parameter int DIV_W = 15  // prescaler width
)
(
    input  wire logic        clk,      // 250 MHz core clock
    input  wire logic        rst_n,    // async reset, active low
    input  wire logic [15:0] addr,     // register address
    input  wire logic [15:0] wdata,    // write data
    input  wire logic        wr,       // write strobe
    input  wire logic        rd,       // read strobe
    output logic      [15:0] rdata,    // read data, cycle after rd
    input  wire logic [2:0]  oscIn,    // oscillator tick pins
    input  wire logic        extClk,   // external count clock pin
    input  wire logic        capAIn,   // capture A pin
    input  wire logic        capBIn,   // capture B pin
    output logic             toutA,    // waveform A
    output logic             toutB,    // waveform B
    output logic             multiMode // multi-unit mode to system
);
    // ========================================================
    // registers
    logic [15:0] ctl_r, ctl_nxt;
    logic [7:0]  clk_r, clk_nxt;
    logic [15:0] cc_r, cc_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic        stopAtEnd_r, stopAtEnd_nxt;
    logic        wave_r, wave_nxt;
    logic        waveB_r, waveB_nxt;
    logic        half_r, half_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [3:0]  sync1_r, sync2_r, srcPrev_r;
    logic [1:0]  cap1_r, cap2_r;
    logic [3:0]  srcTick;
    logic        cntTick, step, periodEnd;
    logic        matchA, matchB;

    pwmtc_unit_if ua ();
    pwmtc_unit_if ub ();

    // ========================================================
    // decoding shared by read and write paths
    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] base);
        hit = (a == base);
    endfunction

    // ========================================================
    // pin synchronisers; only the second stage is read
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_r   <= 4'h0;
            sync2_r   <= 4'h0;
            srcPrev_r <= 4'h0;
            cap1_r    <= 2'b00;
            cap2_r    <= 2'b00;
        end
        else
        begin
            sync1_r   <= {extClk, oscIn};
            sync2_r   <= sync1_r;
            srcPrev_r <= sync2_r;
            cap1_r    <= {capBIn, capAIn};
            cap2_r    <= cap1_r;
        end
    end
    // source ticks on rising edges of the synchronised pins
    assign srcTick = sync2_r & ~srcPrev_r;

    pwmtc_clkdiv #(.DIV_W(DIV_W)) u_div
    (
        .clk     (clk),
        .rst_n   (rst_n),
        .enable  (clk_r[pwmtc_pkg::CLK_EN]),
        .divSel  (clk_r[pwmtc_pkg::CLK_DIV_LO +: 4]),
        .srcTick (srcTick),
        .srcSel  (clk_r[pwmtc_pkg::CLK_SRC_LO +: 2]),
        .tick    (cntTick)
    );

    // ========================================================
    // register writes
    always_comb
    begin
        ctl_nxt = ctl_r;
        clk_nxt = clk_r;
        cc_nxt  = cc_r;
        if (wr && hit(addr, pwmtc_pkg::ADDR_CTL))
            ctl_nxt = wdata & pwmtc_pkg::CTL_RW_MASK;
        if (wr && hit(addr, pwmtc_pkg::ADDR_CLK))
            clk_nxt = wdata[7:0];
        if (wr && hit(addr, pwmtc_pkg::ADDR_CCCTL))
            cc_nxt = wdata & pwmtc_pkg::CC_RW_MASK;
        // one-shot drops the run bit at period end
        if (periodEnd && stopAtEnd_r)
            ctl_nxt[pwmtc_pkg::CTL_RUN] = 1'b0;
    end

    // ========================================================
    // counter; half clock steps on every count tick, else on alternate
    always_comb
    begin
        cnt_nxt       = cnt_r;
        half_nxt      = half_r;
        stopAtEnd_nxt = ctl_r[pwmtc_pkg::CTL_ONESH];
        step          = 1'b0;
        if (ctl_r[pwmtc_pkg::CTL_RUN] && cntTick)
        begin
            // half clock mode doubles the counting rate
            if (ctl_r[pwmtc_pkg::CTL_HALF])
                step = 1'b1;
            else
            begin
                half_nxt = ~half_r;
                step     = half_r;
            end
        end
        if (step)
        begin
            // repeat restarts from zero at match B
            if (periodEnd)
                cnt_nxt = 16'h0000;
            else
                cnt_nxt = cnt_r + 16'h0001;
        end
        if (wr && hit(addr, pwmtc_pkg::ADDR_CTL) &&
            wdata[pwmtc_pkg::CTL_CLR])
        begin
            cnt_nxt  = 16'h0000;
            half_nxt = 1'b0;
        end
    end
    // period closes when the counter reaches compare B
    assign periodEnd = step && (cnt_r == ub.value) &&
                       !cc_r[pwmtc_pkg::CC_BFUNC];

    // ========================================================
    // unit hookup
    // unit A function
    assign ua.funcCapture = cc_r[pwmtc_pkg::CC_AFUNC];
    assign ua.trigSel     = cc_r[pwmtc_pkg::CC_ATRG_LO +: 2];
    assign ua.capIn       = cap2_r[0];
    assign ua.wrStb       = wr && hit(addr, pwmtc_pkg::ADDR_CCA);
    assign ua.wrData      = wdata;
    assign ua.bufOn       = ctl_r[pwmtc_pkg::CTL_BUF];
    assign ua.reload      = periodEnd;
    assign ua.count       = cnt_r;
    assign ub.funcCapture = cc_r[pwmtc_pkg::CC_BFUNC];
    assign ub.trigSel     = cc_r[pwmtc_pkg::CC_BTRG_LO +: 2];
    assign ub.capIn       = cap2_r[1];
    assign ub.wrStb       = wr && hit(addr, pwmtc_pkg::ADDR_CCB);
    assign ub.wrData      = wdata;
    assign ub.bufOn       = ctl_r[pwmtc_pkg::CTL_BUF];
    assign ub.reload      = periodEnd;
    assign ub.count       = cnt_r;
    assign matchA         = ua.match;
    assign matchB         = ub.match;

    pwmtc_unit u_a (.clk(clk), .rst_n(rst_n), .u(ua.unit));
    pwmtc_unit u_b (.clk(clk), .rst_n(rst_n), .u(ub.unit));

    // ========================================================
    // waveforms: mode 1 set on A clear on B, 2 toggle on A, 3 on B
    function automatic logic waveNext(input logic cur,
                                      input logic [1:0] md,
                                      input logic ma,
                                      input logic mb);
        unique case (md)
            2'b00: waveNext = 1'b0;
            2'b01: waveNext = mb ? 1'b0 : (ma ? 1'b1 : cur);
            2'b10: waveNext = cur ^ ma;
            2'b11: waveNext = cur ^ mb;
        endcase
    endfunction

    always_comb
    begin
        wave_nxt  = waveNext(wave_r, cc_r[pwmtc_pkg::CC_AMD_LO +: 2],
                             matchA, matchB);
        waveB_nxt = waveNext(waveB_r, cc_r[pwmtc_pkg::CC_BMD_LO +: 2],
                             matchA, matchB);
    end

    // ========================================================
    // read mux; unmapped addresses and clear bit read zero
    always_comb
    begin
        rdata_nxt = 16'h0000;
        if (rd)
        begin
            if (hit(addr, pwmtc_pkg::ADDR_CTL))
                rdata_nxt = ctl_r;
            else if (hit(addr, pwmtc_pkg::ADDR_CNT))
                rdata_nxt = cnt_r;
            else if (hit(addr, pwmtc_pkg::ADDR_CCCTL))
                rdata_nxt = cc_r;
            else if (hit(addr, pwmtc_pkg::ADDR_CCA))
                rdata_nxt = ua.value;
            else if (hit(addr, pwmtc_pkg::ADDR_CCB))
                rdata_nxt = ub.value;
            else if (hit(addr, pwmtc_pkg::ADDR_CLK))
                rdata_nxt = {8'h00, clk_r};
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_r       <= pwmtc_pkg::RST_REG16;
            clk_r       <= pwmtc_pkg::RST_REG8;
            cc_r        <= pwmtc_pkg::RST_REG16;
            cnt_r       <= pwmtc_pkg::RST_REG16;
            stopAtEnd_r <= 1'b0;
            wave_r      <= 1'b0;
            waveB_r     <= 1'b0;
            half_r      <= 1'b0;
            rdata_r     <= pwmtc_pkg::RST_REG16;
        end
        else
        begin
            ctl_r       <= ctl_nxt;
            clk_r       <= clk_nxt;
            cc_r        <= cc_nxt;
            cnt_r       <= cnt_nxt;
            stopAtEnd_r <= stopAtEnd_nxt;
            wave_r      <= wave_nxt;
            waveB_r     <= waveB_nxt;
            half_r      <= half_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    // inversion applied after the registered wave
    assign toutA     = wave_r ^ cc_r[pwmtc_pkg::CC_AINV];
    assign toutB     = waveB_r ^ cc_r[pwmtc_pkg::CC_BINV];
    assign multiMode = clk_r[pwmtc_pkg::CLK_MULTI];
    assign rdata     = rdata_r;
endmodule

// [bench/pwmtc_timer_checker.sv]
// checker: register port assertions for the pwm timer top
`timescale 1ns/1ps
module pwmtc_timer_checker
(
    input wire logic        clk,       // core clock
    input wire logic        rst_n,     // async reset, active low
    input wire logic [15:0] addr,      // register address
    input wire logic [15:0] wdata,     // write data
    input wire logic        wr,        // write strobe
    input wire logic        rd,        // read strobe
    input wire logic [15:0] rdata,     // read data
    input wire logic        multiMode  // multi mode output
);
    logic aCap_r;   // unit a capture shadow
    logic aCap_nxt; // next shadow value
    logic bCap_r;   // unit b capture shadow
    logic bCap_nxt; // next b shadow value
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ========================================================
    // capture mode shadow: captures may overwrite unit a and unit b values
    always_comb
    begin
        aCap_nxt = aCap_r;
        bCap_nxt = bCap_r;
        if (wr && addr == pwmtc_pkg::ADDR_CCCTL)
        begin
            aCap_nxt = wdata[0];
            bCap_nxt = wdata[8];
        end
    end
    // shadow register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aCap_r <= 1'h0;
            bCap_r <= 1'h0;
        end
        else
        begin
            aCap_r <= aCap_nxt;
            bCap_r <= bCap_nxt;
        end
    end
    // write then read of the same place, back to back
    sequence s_wr_rd(logic [15:0] a, logic en);
        en && wr && addr == a ##1 rd && addr == a;
    endsequence
    // ========================================================
    // assertions
    a_clear_reads_zero: assert property (
        rd && addr == pwmtc_pkg::ADDR_CTL |=>
        rdata[1] == 1'h0 && rdata[15:7] == 9'h000)
        else $error("clear or reserved control bit read as one");
    a_clear_zeroes_cnt: assert property (
        wr && addr == pwmtc_pkg::ADDR_CTL && wdata[1:0] == 2'h2 ##1
        rd && addr == pwmtc_pkg::ADDR_CNT |=> rdata == 16'h0000)
        else $error("counter not zero after clear");
    a_ctl_back: assert property (
        s_wr_rd(pwmtc_pkg::ADDR_CTL, !wdata[2]) |=>
        rdata == ($past(wdata, 2) & pwmtc_pkg::CTL_RW_MASK))
        else $error("control readback differs");
    a_trig_back: assert property (
        s_wr_rd(pwmtc_pkg::ADDR_CCCTL, 1'h1) |=>
        rdata == ($past(wdata, 2) & pwmtc_pkg::CC_RW_MASK))
        else $error("compare capture control readback differs");
    a_clk_back: assert property (
        s_wr_rd(pwmtc_pkg::ADDR_CLK, 1'h1) |=>
        rdata == {8'h00, $past(wdata[7:0], 2)})
        else $error("count clock control readback differs");
    a_multi_follows: assert property (
        wr && addr == pwmtc_pkg::ADDR_CLK |=> multiMode == $past(wdata[1]))
        else $error("multi mode output not following its bit");
    a_a_value_back: assert property (
        s_wr_rd(pwmtc_pkg::ADDR_CCA, !aCap_r) |=> rdata == $past(wdata, 2))
        else $error("unit a value readback differs");
    a_b_value_back: assert property (
        s_wr_rd(pwmtc_pkg::ADDR_CCB, !bCap_r) |=> rdata == $past(wdata, 2))
        else $error("unit b value readback differs");
endmodule
bind pwmtc_timer pwmtc_timer_checker chk_i
(
    .clk       (clk),
    .rst_n     (rst_n),
    .addr      (addr),
    .wdata     (wdata),
    .wr        (wr),
    .rd        (rd),
    .rdata     (rdata),
    .multiMode (multiMode)
);

// [bench/tb_pwm_timer_capture_compare.sv]
// testbench: registers, counting and capture of the pwm timer
`timescale 1ns/1ps
module tb_pwm_timer_capture_compare;
    logic        clk;        // core clock
    logic        rst_n;      // reset, active low
    logic [15:0] addr;       // bus address
    logic [15:0] wdata;      // bus write data
    logic        wr;         // write strobe
    logic        rd;         // read strobe
    logic [15:0] rdata;      // bus read data
    logic        extClk;     // external count clock
    logic        capIn;      // both capture pins
    logic        multiMode;  // multi mode output
    logic        toutA;      // waveform a
    logic        toutB;      // waveform b
    logic [15:0] q;          // read result
    logic [15:0] q2;         // second read result
    logic [15:0] d;          // value written
    logic [15:0] aM;         // unit a model
    logic [15:0] bM;         // unit b model
    logic [15:0] v;          // stopped counter value
    int          seed;       // random seed
    int          nErrors;    // mismatch count
    int          checksDone; // comparison count
    // ========================================================
    // device; small prescaler keeps the run short
    pwmtc_timer #(.DIV_W(4)) dut
    (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .oscIn(3'h0),
        .extClk(extClk), .capAIn(capIn), .capBIn(capIn),
        .toutA(toutA), .toutB(toutB), .multiMode(multiMode)
    );
    // 250 MHz clock
    always #2 clk = ~clk;
    // ========================================================
    // helpers; every task starts and ends just after a rising edge
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            nErrors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rreg(input logic [15:0] a, output logic [15:0] r);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        r = rdata;
        @(posedge clk);
    endtask
    // write followed at once by a read, no gap
    task automatic wrd(input logic [15:0] wa, input logic [15:0] dv,
                       input logic [15:0] ra, output logic [15:0] r);
        addr <= wa;
        wdata <= dv;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rreg(ra, r);
    endtask
    // write plus a readback into q2; trailing edge keeps strobes from colliding
    task automatic wreg(input logic [15:0] a, input logic [15:0] dv);
        wrd(a, dv, a, q2);
    endtask
    task automatic edges(input int n);
        repeat (n)
        begin
            extClk <= 1'b1;
            repeat (4) @(posedge clk);
            extClk <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    // clear, run for n source edges, stop, read the counter
    task automatic cnt(input logic [15:0] c, input int n,
                       output logic [15:0] r);
        wrd(pwmtc_pkg::ADDR_CTL, 16'h0002, pwmtc_pkg::ADDR_CNT, r);
        chk(r, 16'h0000);
        wreg(pwmtc_pkg::ADDR_CTL, c);
        edges(n);
        wreg(pwmtc_pkg::ADDR_CTL, c & 16'hFFFE);
        rreg(pwmtc_pkg::ADDR_CNT, r);
    endtask
    task automatic stopTest;
        $display("checks %0d errors %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog against a hang
    initial
    begin
        #100000;
        nErrors++;
        stopTest();
    end
    // ========================================================
    // main sequence
    initial
    begin
        clk = 0; rst_n = 0; addr = 0; wdata = 0; wr = 0; rd = 0;
        extClk = 0; capIn = 0; seed = 945; nErrors = 0; checksDone = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // read-only counter and unmapped place ignore writes
        wreg(pwmtc_pkg::ADDR_CNT, 16'hFFFF);
        wreg(16'h540E, 16'hFFFF);
        for (int i = 0; i < 7; i++)
        begin
            rreg(16'h5400 + 16'(2 * i), q);
            chk(q, 16'h0000);
        end
        rreg(pwmtc_pkg::ADDR_CLK, q);
        chk(q, 16'h0000);
        // random readback, every trigger code on both units
        for (int i = 0; i < 4; i++)
        begin
            d = 16'($random(seed));
            wrd(pwmtc_pkg::ADDR_CCA, d, pwmtc_pkg::ADDR_CCA, q);
            chk(q, d);
            wrd(pwmtc_pkg::ADDR_CCB, ~d, pwmtc_pkg::ADDR_CCB, q);
            chk(q, ~d);
            d = (16'($random(seed)) & 16'h3F3F) |
                {i[1:0], 6'h00, i[1:0], 6'h00};
            wrd(pwmtc_pkg::ADDR_CCCTL, d, pwmtc_pkg::ADDR_CCCTL, q);
            chk(q, d & pwmtc_pkg::CC_RW_MASK);
            wrd(pwmtc_pkg::ADDR_CLK, d, pwmtc_pkg::ADDR_CLK, q);
            chk(q, d & 16'h00FF);
            chk({15'h0000, multiMode}, {15'h0000, d[1]});
            d = d & 16'hFFFA;
            wrd(pwmtc_pkg::ADDR_CTL, d, pwmtc_pkg::ADDR_CTL, q);
            chk(q, d & pwmtc_pkg::CTL_RW_MASK);
        end
        // waveforms idle low; the invert bits flip both outputs
        wreg(pwmtc_pkg::ADDR_CCCTL, 16'h0000);
        chk({14'h0000, toutB, toutA}, 16'h0000);
        wreg(pwmtc_pkg::ADDR_CCCTL, 16'h0202);
        chk({14'h0000, toutB, toutA}, 16'h0003);
        wreg(pwmtc_pkg::ADDR_CCCTL, 16'h0000);
        // counting from the external source
        wreg(pwmtc_pkg::ADDR_CCB, 16'hFFFF);
        wreg(pwmtc_pkg::ADDR_CLK, 16'h000D);
        cnt(16'h0001, 8, q);
        chk(16'(q >= 3 && q <= 5), 16'h0001);
        edges(3);
        rreg(pwmtc_pkg::ADDR_CNT, q2);
        chk(q2, q);
        cnt(16'h0041, 8, q);
        chk(q, 16'h0008);
        wreg(pwmtc_pkg::ADDR_CLK, 16'h002D);
        cnt(16'h0041, 16, q);
        chk(16'(q >= 3 && q <= 5), 16'h0001);
        wreg(pwmtc_pkg::ADDR_CLK, 16'h000D);
        wreg(pwmtc_pkg::ADDR_CCB, 16'h0003);
        cnt(16'h0041, 10, q);
        chk(q, 16'(10 % 4));
        v = q;
        // capture on each trigger code, counter held at v
        for (int t = 0; t < 4; t++)
        begin
            wreg(pwmtc_pkg::ADDR_CCCTL, {t[1:0], 6'h01, t[1:0], 6'h01});
            aM = 16'($random(seed));
            bM = ~aM;
            wreg(pwmtc_pkg::ADDR_CCA, aM);
            wreg(pwmtc_pkg::ADDR_CCB, bM);
            for (int e = 1; e >= 0; e--)
            begin
                capIn <= e[0];
                repeat (6) @(posedge clk);
                if (t[1 - e])
                begin
                    aM = v;
                    bM = v;
                end
                rreg(pwmtc_pkg::ADDR_CCA, q);
                chk(q, aM);
                rreg(pwmtc_pkg::ADDR_CCB, q);
                chk(q, bM);
            end
        end
        // one-shot stops at the period end
        wreg(pwmtc_pkg::ADDR_CCCTL, 16'h0000);
        wreg(pwmtc_pkg::ADDR_CCB, 16'h0003);
        wrd(pwmtc_pkg::ADDR_CTL, 16'h0002, pwmtc_pkg::ADDR_CNT, q);
        wreg(pwmtc_pkg::ADDR_CTL, 16'h0045);
        edges(10);
        rreg(pwmtc_pkg::ADDR_CNT, q);
        chk(q, 16'h0000);
        rreg(pwmtc_pkg::ADDR_CTL, q);
        chk(q, 16'h0044);
        stopTest();
    end
endmodule
